//--- shared/swcp_pkg.sv
// Shared constants for the single-wire configuration programming block.
// Assumes a 100 MHz reference clock and a device basic clock derived from it.
package swcp_pkg;

	// Reference clock period, in units of 100 ps
	localparam int REF_CLK_PERIOD_100PS = 100;
	// Device basic clock period, 2.0662 us, in units of 100 ps
	localparam int T_CLK_PERIOD_100PS = 20662;
	// Reference cycles per basic clock tick, rounded down
	localparam int TICK_DIV = T_CLK_PERIOD_100PS / REF_CLK_PERIOD_100PS;

	// Width of every tick counter
	localparam int TICK_W = 14;
	// Bits in one configuration word
	localparam int WORD_BITS = 15;
	// Width of the bit counter
	localparam int BIT_W = 4;

	// Short start pulse must stay below 5632 basic clock periods
	localparam logic [TICK_W-1:0] SHORT_START_MAX_TICKS = 14'h1600;
	// Long start pulse must exceed 7936 basic clock periods
	localparam logic [TICK_W-1:0] LONG_START_MIN_TICKS = 14'h1F00;
	// Saturation value of the low-time counter
	localparam logic [TICK_W-1:0] LOW_CNT_MAX = 14'h3FFF;
	// Last bit index of a word
	localparam logic [BIT_W-1:0] LAST_BIT = 4'hE;

	// First received bit (bit 1) lands at the top of the word
	localparam int OFF_BIT_IDX = 14;
	// Bit 2 selects the target register
	localparam int SEL_BIT_IDX = 13;

	// Transfer sequencer states
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_DELAY,
		ST_FRAME,
		ST_EQUAL
	} state_type;

endpackage

//--- logic/basic_clock_divider.sv
// Divider that turns the reference clock into the basic clock tick.
// Assumes one reference clock and a synchronous active-high reset.
`timescale 1ns/1ps
module basic_clock_divider #(
	parameter int DIV = 206
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	output logic      o_tick
);

	// Counter wide enough for any sane divide ratio
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;   // Position inside one tick period

	// Refuse ratios that produce no tick
	if (DIV < 2)
	begin : g_chk_div
		$error("Divide ratio must be at least two");
	end

	// Free-running count, one tick pulse per wrap
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end
		else if (cnt_q == LAST)
		begin
			cnt_q  <= '0;
			o_tick <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + CW'(1);
			o_tick <= 1'b0;
		end
	end

endmodule

//--- logic/single_wire_config_programming.sv
// Receiver-side logic of the single open-drain configuration data line.
// Assumes an external pull-up on the line and a supply monitor on I_POR.
//
// How it works
// R1 - Supply reset loads default configuration values
// R2 - Internal reset held minimum period after supply
// R3 - Reset marker square wave, 50% duty, persists
// R4 - Marker slower than any valid data signal
// R5 - Host starts with low pulse, then releases
// R6 - Fifteen sync pulses after programming delay
// R7 - Window after each sync, fixed frame time
// R8 - Host low pulse stores zero, else one
// R9 - Fifteen bits captured form the word
// R10 - Acknowledge pulse only when word matches stored
// R11 - Host writes twice to confirm transfer
// R12 - Programming accepted in sleep or active
// R13 - Receive path disabled while programming
// R14 - Bit one set also means off command
// R15 - Short start ignored while marker present
// R16 - Long start always programs, restores, cancels marker
// R17 - Host uses long start after seeing marker
// R18 - Line only driven low, else released
`timescale 1ns/1ps
module single_wire_config_programming
	import swcp_pkg::*;
#(
	parameter logic [TICK_W-1:0]    T_RST_TICKS   = 14'h0064,
	parameter logic [TICK_W-1:0]    MARKER_HALF   = 14'h0040,
	parameter logic [TICK_W-1:0]    DATA_HALF_MAX = 14'h0030,
	parameter logic [TICK_W-1:0]    T_START_MIN   = 14'h00A0,
	parameter logic [TICK_W-1:0]    T2_TICKS      = 14'h0032,
	parameter logic [TICK_W-1:0]    T3_TICKS      = 14'h0014,
	parameter logic [TICK_W-1:0]    T4_TICKS      = 14'h000A,
	parameter logic [TICK_W-1:0]    T5_TICKS      = 14'h003C,
	parameter logic [TICK_W-1:0]    T6_TICKS      = 14'h0064,
	parameter logic [TICK_W-1:0]    T_ZERO_TICKS  = 14'h0014,
	parameter logic [TICK_W-1:0]    T_MATCH_TICKS = 14'h0014,
	parameter logic [TICK_W-1:0]    T9_TICKS      = 14'h003C,
	parameter logic [WORD_BITS-1:0] OPER_CFG_DFLT = 15'h0000,
	parameter logic [WORD_BITS-1:0] LIMIT_DFLT    = 15'h0000,
	parameter int                   TICK_DIVIDE   = TICK_DIV
) (
	input  wire logic                 I_REF_CLK,
	input  wire logic                 I_RST,
	input  wire logic                 I_POR,
	input  wire logic                 I_DATA_IN,
	output logic                      O_DATA_OUT,
	output logic                      O_DATA_OE_N,
	output logic                      O_RESET_MARKER,
	output logic                      O_RX_DISABLE,
	output logic                      O_POLLING_CMD,
	output logic                      O_CONFIG_VALID,
	output logic [WORD_BITS-1:0]      O_CONFIG_WORD,
	output logic [WORD_BITS-1:0]      O_OPERATING_CONFIG,
	output logic [WORD_BITS-1:0]      O_LIMIT
);

	// Window start and end inside a frame
	localparam logic [TICK_W-1:0] WIN_START = T3_TICKS + T4_TICKS;
	localparam logic [TICK_W-1:0] WIN_END   = T3_TICKS + T4_TICKS + T5_TICKS;

	// Timing sets the logic cannot serve
	if (WIN_END > T6_TICKS || T_ZERO_TICKS > T5_TICKS || T_MATCH_TICKS > T9_TICKS)
	begin : g_chk_frame
		$error("Frame timing does not fit");
	end
	// Marker must be slower than data and shorter than a start pulse
	if (MARKER_HALF <= DATA_HALF_MAX || T_START_MIN <= MARKER_HALF) // R4
	begin : g_chk_marker
		$error("Marker timing overlaps data or start pulse");
	end

	logic                 data_meta_q;   // Line synchroniser, first stage
	logic                 data_sync_q;   // Line synchroniser, second stage
	logic                 por_meta_q;    // Supply reset synchroniser, first stage
	logic                 por_sync_q;    // Supply reset synchroniser, second stage
	logic                 tick;          // Basic clock enable
	logic                 int_rst_q;     // Internal reset, held after supply recovers
	logic [TICK_W-1:0]    hold_cnt_q;    // Reset hold counter
	logic                 low_prev_q;    // Line was low one cycle ago
	logic [TICK_W-1:0]    low_cnt_q;     // Length of current low phase
	logic                 release_ev;    // Line just went high
	logic                 start_long;    // Accepted long start pulse
	logic                 start_short;   // Accepted short start pulse
	logic                 go;            // A transfer begins
	logic                 marker_on_q;   // Reset marker pending
	logic                 marker_ph_q;   // Marker low half when set
	logic [TICK_W-1:0]    marker_cnt_q;  // Marker half-period counter
	state_type            state_q;       // Transfer sequencer
	logic [TICK_W-1:0]    cnt_q;         // Position inside delay, frame or window
	logic [BIT_W-1:0]     bit_cnt_q;     // Bit being programmed
	logic [TICK_W-1:0]    win_low_q;     // Low ticks seen in current window
	logic [WORD_BITS-1:0] shift_q;       // Word being received
	logic                 eq_match_q;    // New word equals stored one
	logic                 drive_low_d;   // Line pull-down request
	logic                 drive_low_q;   // Registered pull-down
	logic                 in_window;     // Inside the programming window
	logic                 bit_zero;      // Host sent a zero in this frame
	logic                 frame_end;     // Last tick of a bit frame
	logic                 eq_end;        // Last tick of equivalence window
	logic [WORD_BITS-1:0] new_word;      // Complete word including last bit
	logic                 sel_limit;     // Word targets the limit register

	// Basic clock tick from the reference clock
	basic_clock_divider #(
		.DIV    (TICK_DIVIDE)
	) u_tick (
		.i_clk  (I_REF_CLK),
		.i_rst  (I_RST),
		.o_tick (tick)
	);

	// Two-stage synchronisers for the pin and the supply monitor
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST)
		begin
			data_meta_q <= 1'b1;
			data_sync_q <= 1'b1;
			por_meta_q  <= 1'b1;
			por_sync_q  <= 1'b1;
		end
		else
		begin
			data_meta_q <= I_DATA_IN;
			data_sync_q <= data_meta_q;
			por_meta_q  <= I_POR;
			por_sync_q  <= por_meta_q;
		end
	end

	// Internal reset stays on for the hold period after supply recovers
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST || por_sync_q)
		begin
			int_rst_q  <= 1'b1;
			hold_cnt_q <= '0;
		end
		else if (int_rst_q && tick)
		begin
			if (hold_cnt_q == T_RST_TICKS - 14'h0001)
				int_rst_q <= 1'b0; // R2
			else
				hold_cnt_q <= hold_cnt_q + 14'h0001;
		end
	end

	// Low-time measurement of the line, only while idle
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST)
		begin
			low_prev_q <= 1'b0;
			low_cnt_q  <= '0;
		end
		else
		begin
			low_prev_q <= ~data_sync_q;
			// Restart on every high level
			if (data_sync_q || state_q != ST_IDLE)
				low_cnt_q <= '0;
			else if (tick && low_cnt_q != LOW_CNT_MAX)
				low_cnt_q <= low_cnt_q + 14'h0001;
		end
	end

	// Release ends the host start pulse; the device takes over timing
	assign release_ev  = low_prev_q && data_sync_q && state_q == ST_IDLE; // R5
	assign start_long  = release_ev && low_cnt_q > LONG_START_MIN_TICKS; // R16
	// Between the two bands the pulse is simply ignored
	assign start_short = release_ev && low_cnt_q > T_START_MIN
		&& low_cnt_q < SHORT_START_MAX_TICKS && !marker_on_q; // R15
	// Sleep or active makes no difference here
	assign go = (start_long || start_short) && !int_rst_q; // R12

	// Reset marker: armed by any reset, cancelled only by a long start
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST || int_rst_q)
		begin
			marker_on_q  <= 1'b1; // R3
			marker_ph_q  <= 1'b0;
			marker_cnt_q <= '0;
		end
		else if (go && start_long)
			marker_on_q <= 1'b0; // R16
		else if (marker_on_q && tick)
		begin
			// Equal halves give the 50% duty cycle
			if (marker_cnt_q == MARKER_HALF - 14'h0001)
			begin
				marker_cnt_q <= '0;
				marker_ph_q  <= ~marker_ph_q; // R3
			end
			else
				marker_cnt_q <= marker_cnt_q + 14'h0001;
		end
	end

	// Frame decode helpers
	assign in_window = cnt_q >= WIN_START && cnt_q < WIN_END; // R7
	assign bit_zero  = win_low_q >= T_ZERO_TICKS; // R8
	assign frame_end = tick && cnt_q == T6_TICKS - 14'h0001;
	assign eq_end    = tick && cnt_q == T9_TICKS - 14'h0001;
	assign new_word  = {shift_q[WORD_BITS-2:0], ~bit_zero}; // R9
	assign sel_limit = shift_q[SEL_BIT_IDX];

	// Transfer sequencer: delay, fifteen frames, equivalence window
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST || int_rst_q)
		begin
			state_q   <= ST_IDLE;
			cnt_q     <= '0;
			bit_cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					cnt_q     <= '0;
					bit_cnt_q <= '0;
					if (go)
						state_q <= ST_DELAY;
				end
				ST_DELAY:
				begin
					// Programming delay before the first sync pulse
					if (tick && cnt_q == T2_TICKS - 14'h0001)
					begin
						cnt_q   <= '0;
						state_q <= ST_FRAME; // R6
					end
					else if (tick)
						cnt_q <= cnt_q + 14'h0001;
				end
				ST_FRAME:
				begin
					if (frame_end)
					begin
						cnt_q <= '0;
						if (bit_cnt_q == LAST_BIT)
							state_q <= ST_EQUAL; // R9
						else
							bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					else if (tick)
						cnt_q <= cnt_q + 14'h0001;
				end
				ST_EQUAL:
				begin
					if (eq_end)
						state_q <= ST_IDLE;
					else if (tick)
						cnt_q <= cnt_q + 14'h0001;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Window sampling and word assembly, first bit ends at the top
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST || int_rst_q)
		begin
			win_low_q  <= '0;
			shift_q    <= '0;
			eq_match_q <= 1'b0;
		end
		else if (state_q == ST_FRAME)
		begin
			if (frame_end)
			begin
				win_low_q <= '0;
				shift_q   <= new_word; // R8
				// Compare against the register the word targets
				if (bit_cnt_q == LAST_BIT)
					eq_match_q <= new_word == (new_word[SEL_BIT_IDX] ? O_LIMIT
						: O_OPERATING_CONFIG); // R10
			end
			else if (tick && in_window && !data_sync_q)
				win_low_q <= win_low_q + 14'h0001; // R8
		end
		else if (state_q == ST_IDLE)
			win_low_q <= '0;
	end

	// Configuration registers, written after the equivalence window
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST || int_rst_q)
		begin
			O_OPERATING_CONFIG <= OPER_CFG_DFLT; // R1
			O_LIMIT            <= LIMIT_DFLT; // R1
		end
		else if (go && start_long)
		begin
			O_OPERATING_CONFIG <= OPER_CFG_DFLT; // R16
			O_LIMIT            <= LIMIT_DFLT; // R16
		end
		else if (state_q == ST_EQUAL && eq_end)
		begin
			if (sel_limit)
				O_LIMIT <= shift_q;
			else
				O_OPERATING_CONFIG <= shift_q;
		end
	end

	// Word report and off command, one cycle each
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST || int_rst_q)
		begin
			O_CONFIG_VALID <= 1'b0;
			O_POLLING_CMD  <= 1'b0;
			O_CONFIG_WORD  <= '0;
		end
		else
		begin
			O_CONFIG_VALID <= state_q == ST_EQUAL && eq_end;
			O_POLLING_CMD  <= state_q == ST_EQUAL && eq_end && shift_q[OFF_BIT_IDX]; // R14
			if (state_q == ST_EQUAL && eq_end)
				O_CONFIG_WORD <= shift_q;
		end
	end

	// Pull-down request: marker low half, sync pulse, acknowledge
	always_comb
	begin
		drive_low_d = 1'b0;
		case (state_q)
			ST_IDLE:  drive_low_d = marker_on_q && marker_ph_q; // R3
			ST_FRAME: drive_low_d = cnt_q < T3_TICKS; // R6
			ST_EQUAL: drive_low_d = eq_match_q && cnt_q < T_MATCH_TICKS; // R10
			default:  drive_low_d = 1'b0;
		endcase
	end

	// Registered open-drain drive; the pad only ever pulls low
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_RST)
			drive_low_q <= 1'b0;
		else
			drive_low_q <= drive_low_d;
	end

	assign O_DATA_OUT     = 1'b0; // R18
	assign O_DATA_OE_N    = ~drive_low_q; // R18
	assign O_RESET_MARKER = marker_on_q;
	// Receive path off for the whole sequence
	assign O_RX_DISABLE   = state_q != ST_IDLE; // R13

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);

	AST_RST_DEFAULTS: assert property (int_rst_q |=> O_OPERATING_CONFIG == OPER_CFG_DFLT // R1
		&& O_LIMIT == LIMIT_DFLT)
		else $error("Defaults not loaded in reset");
	AST_RST_HOLD: assert property ($fell(int_rst_q) |-> $past(hold_cnt_q) == T_RST_TICKS - 14'h0001) // R2
		else $error("Internal reset released early");
	AST_MARKER_ARMED: assert property ($fell(int_rst_q) |-> marker_on_q && !marker_ph_q) // R3
		else $error("Marker not armed after reset");
	AST_MARKER_TOGGLE: assert property ((!int_rst_q && marker_on_q && tick && !go
		&& marker_cnt_q == MARKER_HALF - 14'h0001) |=> marker_ph_q != $past(marker_ph_q)) // R3
		else $error("Marker half period wrong");
	AST_SHORT_IGNORED: assert property ((release_ev && marker_on_q
		&& low_cnt_q <= LONG_START_MIN_TICKS) |=> state_q == ST_IDLE) // R15
		else $error("Short start accepted during marker");
	AST_LONG_CANCELS: assert property ((go && start_long) |=> !marker_on_q // R16
		##1 O_OPERATING_CONFIG == OPER_CFG_DFLT)
		else $error("Long start did not cancel marker");
	AST_RX_OFF: assert property (go |=> O_RX_DISABLE [*3]) // R13
		else $error("Receive path not disabled");
	AST_SYNC_DRIVE: assert property ((state_q == ST_FRAME && cnt_q < T3_TICKS) |=> !O_DATA_OE_N) // R6
		else $error("Sync pulse not driven");
	AST_NO_ACK: assert property ((state_q == ST_EQUAL && !eq_match_q) |=> O_DATA_OE_N) // R10
		else $error("Acknowledge without match");
	AST_OFF_CMD: assert property (O_POLLING_CMD |-> O_CONFIG_VALID && O_CONFIG_WORD[OFF_BIT_IDX]) // R14
		else $error("Off command without bit one");
	AST_BIT_RANGE: assert property (state_q == ST_FRAME |-> bit_cnt_q <= LAST_BIT) // R9
		else $error("Bit counter overran");
	AST_ZERO_BIT: assert property ((state_q == ST_FRAME && frame_end && bit_zero)
		|=> !shift_q[0]) // R8
		else $error("Zero bit not stored");

endmodule

//--- verif/host_mcu_model.sv
// Host controller model on the open-drain configuration data line.
// Assumes an external pull-up: a released line reads high.
`timescale 1ns/1ps
module host_mcu_model
	import swcp_pkg::*;
#(
	parameter int T2     = 4,
	parameter int T3     = 2,
	parameter int T4     = 1,
	parameter int T6     = 10,
	parameter int ZPULSE = 2,
	parameter int T9     = 6,
	parameter int MHALF  = 4,
	parameter int DIV    = TICK_DIV
) (
	input  wire logic i_clk,
	input  wire logic i_dev_out,
	input  wire logic i_dev_oe_n,
	output logic      o_line
);
	logic pull_q = 1'b0; // Host pulls the line low
	int   stamp  = 0;    // Free-running cycle count

	// Wired-AND; unknown device pins count as released
	assign o_line = !(pull_q || (i_dev_oe_n === 1'b0 && i_dev_out === 1'b0));

	// Time base for frame spacing
	always @(posedge i_clk)
		stamp <= stamp + 1;

	// Wait while line sits at lvl, bounded
	task automatic hold(input logic lvl, input int lim, output int n);
		n = 0;
		while (o_line === lvl && n < lim)
		begin
			@(posedge i_clk);
			n++;
		end
	endtask

	// Start request, then hand timing to the device
	task automatic start_pulse(input int ticks);
		@(posedge i_clk);
		pull_q <= 1'b1;
		repeat (ticks * DIV) @(posedge i_clk);
		pull_q <= 1'b0;
		@(posedge i_clk);
	endtask

	// Full transfer; slow moves the answer late in the window
	task automatic write_word(input logic [WORD_BITS-1:0] w, input int ticks,
		input logic slow, output logic ack, output int nok);
		int n;
		int len;
		int k;
		int prev;
		int d;
		ack = 1'b0;
		nok = 0;
		prev = 0;
		start_pulse(ticks);
		// A marker low half may still hold the line after release
		hold(1'b0, (MHALF + 2) * DIV, n);
		for (int i = WORD_BITS - 1; i >= 0; i--)
		begin
			hold(1'b1, (T2 + T6 + 4) * DIV, n);
			k = stamp;
			hold(1'b0, (T3 + 4) * DIV, len);
			d = k - prev - T6 * DIV;
			// Sync length and frame spacing both within two cycles
			if (len >= T3 * DIV - 2 && len <= T3 * DIV + 2
				&& (i == WORD_BITS - 1 || (d >= -2 && d <= 2)))
				nok++;
			prev = k;
			repeat ((T4 + slow) * DIV + DIV / 2) @(posedge i_clk);
			// Zero bit: pull low inside the window
			if (!w[i])
			begin
				pull_q <= 1'b1;
				repeat ((ZPULSE + 1 + slow) * DIV) @(posedge i_clk);
				pull_q <= 1'b0;
				@(posedge i_clk);
			end
		end
		// Any device low now is the equivalence acknowledge
		repeat ((T6 + T9 + 2) * DIV)
		begin
			@(posedge i_clk);
			if (!o_line)
				ack = 1'b1;
		end
	endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the single-wire configuration programming block.
// Assumes the host model owns the line; design assertions run alongside.
`timescale 1ns/1ps
module tb_top;
	import swcp_pkg::*;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp=%h got=%h", nm, e, g); end end

	localparam int P2 = 4, P3 = 2, P4 = 1, P5 = 6, P6 = 10, P7 = 2, P8 = 2, P9 = 6;
	localparam int PR = 4, PM = 4, PD = 3, P1 = 6;
	localparam int PT = 2; // Short tick divide keeps the long start within budget

	logic                 clk = 1'b0; // Reference clock
	logic                 rst = 1'b1; // Synchronous reset
	logic                 por = 1'b0; // Supply monitor reset
	logic                 line;       // Resolved data line
	logic                 dout, oe_n, marker, rxd, poll, valid;
	logic [WORD_BITS-1:0] word, opm, lim;
	logic [WORD_BITS-1:0] exp_op, exp_lim, w;
	int                   seed = 7;
	int                   miscompares = 0;
	int                   num_checks = 0;
	int                   valid_cnt = 0, poll_cnt = 0, rx_cnt = 0, n, r0;

	always #5 clk = ~clk;

	single_wire_config_programming #(
		.T_RST_TICKS(TICK_W'(PR)), .MARKER_HALF(TICK_W'(PM)), .DATA_HALF_MAX(TICK_W'(PD)),
		.T_START_MIN(TICK_W'(P1)), .T2_TICKS(TICK_W'(P2)), .T3_TICKS(TICK_W'(P3)),
		.T4_TICKS(TICK_W'(P4)), .T5_TICKS(TICK_W'(P5)), .T6_TICKS(TICK_W'(P6)),
		.T_ZERO_TICKS(TICK_W'(P7)), .T_MATCH_TICKS(TICK_W'(P8)), .T9_TICKS(TICK_W'(P9)),
		.TICK_DIVIDE(PT)
	) uut (
		.I_REF_CLK(clk), .I_RST(rst), .I_POR(por), .I_DATA_IN(line),
		.O_DATA_OUT(dout), .O_DATA_OE_N(oe_n), .O_RESET_MARKER(marker),
		.O_RX_DISABLE(rxd), .O_POLLING_CMD(poll), .O_CONFIG_VALID(valid),
		.O_CONFIG_WORD(word), .O_OPERATING_CONFIG(opm), .O_LIMIT(lim)
	);

	host_mcu_model #(.T2(P2), .T3(P3), .T4(P4), .T6(P6), .ZPULSE(P7), .T9(P9), .MHALF(PM),
		.DIV(PT)) host (
		.i_clk(clk), .i_dev_out(dout), .i_dev_oe_n(oe_n), .o_line(line)
	);

	// Pulse and busy tallies, so one-cycle outputs are never missed
	always @(posedge clk)
	begin
		valid_cnt <= valid_cnt + (valid === 1'b1);
		poll_cnt <= poll_cnt + (poll === 1'b1);
		rx_cnt <= rx_cnt + (rxd === 1'b1);
	end

	// Acknowledge only when the word equals its target register
	function automatic logic exp_ack(input logic [WORD_BITS-1:0] v);
		return (v[13] ? exp_lim : exp_op) === v;
	endfunction

	// Cycles for which the line enable stays at lvl
	task automatic meas(input logic lvl, output int c);
		c = 0;
		while (oe_n === lvl && c < 4000)
		begin
			@(posedge clk);
			c++;
		end
	endtask

	// One transfer with every port-visible outcome compared
	task automatic do_write(input logic [WORD_BITS-1:0] v, input int st);
		int v0, p0, q0, nok, c;
		logic ack, ea;
		v0 = valid_cnt;
		p0 = poll_cnt;
		q0 = rx_cnt;
		ea = exp_ack(v);
		host.write_word(v, st, 1'($random(seed)), ack, nok);
		c = 0;
		while (valid_cnt == v0 && c < 9000)
		begin
			@(posedge clk);
			c++;
		end
		repeat (2) @(posedge clk);
		if (v[13])
			exp_lim = v;
		else
			exp_op = v;
		`CHK("syncs", 15, nok)
		`CHK("ack", ea, ack)
		`CHK("word", v, word)
		`CHK("operating_config_register", exp_op, opm)
		`CHK("limit", exp_lim, lim)
		`CHK("valid", v0 + 1, valid_cnt)
		`CHK("poll", p0 + v[14], poll_cnt)
		`CHK("rx_busy", 1'b1, rx_cnt - q0 >= 15 * P6 * PT)
		`CHK("rx_end", 1'b0, rxd)
		`CHK("marker", 1'b0, marker)
	endtask

	// Closing point for normal end and watchdog alike
	task automatic print_verdict();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		meas(1'b1, n);
		`CHK("rst_hold", 1'b1, n >= PR * PT)
		`CHK("dflt_op", 15'h0000, opm)
		`CHK("dflt_lim", 15'h0000, lim)
		`CHK("mk_on", 1'b1, marker)
		meas(1'b0, n);
		`CHK("mk_low", 1'b1, n >= PM * PT - 2 && n <= PM * PT + 2)
		`CHK("mk_slow", 1'b1, n > PD * PT)
		meas(1'b1, n);
		`CHK("mk_high", 1'b1, n >= PM * PT - 2 && n <= PM * PT + 2)
		// Long start cancels marker; registers still hold their defaults here
		exp_op = 15'h0000;
		exp_lim = 15'h0000;
		w = (15'($random(seed)) & 15'h1FFF) | 15'h0001;
		do_write(15'h0000, 7940);
		do_write(w, P1 + 3);
		do_write(w, P1 + 3);
		w = 15'($random(seed)) | 15'h6000;
		do_write(w, P1 + 3);
		do_write(w, P1 + 3);
		do_write(15'h7FFF, P1 + 3);
		// Too short and mid-band starts are both ignored
		r0 = rx_cnt;
		host.start_pulse(P1 - 2);
		host.start_pulse(6000);
		repeat (20 * PT) @(posedge clk);
		`CHK("band_ign", r0, rx_cnt)
		// Supply reset after nonzero registers
		por <= 1'b1;
		repeat (4) @(posedge clk);
		por <= 1'b0;
		meas(1'b1, n);
		`CHK("por_op", 15'h0000, opm)
		`CHK("por_lim", 15'h0000, lim)
		// Short start while marker pending is ignored
		r0 = rx_cnt;
		host.start_pulse(P1 + 3);
		repeat (20 * PT) @(posedge clk);
		`CHK("short_ign", r0, rx_cnt)
		`CHK("mk_stay", 1'b1, marker)
		print_verdict();
	end

	// Watchdog sized for one long start, one mid-band start and short transfers
	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
endmodule
